/* File: rtl/dpr_cfg.svh */
// Constants of the dual-port memory: geometry, reset values and cross-port timing.
`ifndef DPR_CFG_SVH
`define DPR_CFG_SVH
`define DPR_ADDR_W 8
`define DPR_DATA_W 16
`define DPR_DEPTH 256
`define DPR_BUS_RESET 16'h0000
`define DPR_AGE_W 4
`define DPR_AGE_MAX 4'hF
`define DPR_CLK_NS 10
`define DPR_SETUP_NS 10
`define DPR_SETUP_CYC (((`DPR_SETUP_NS + `DPR_CLK_NS - 1) / `DPR_CLK_NS) < 1 ? 1 : \
  ((`DPR_SETUP_NS + `DPR_CLK_NS - 1) / `DPR_CLK_NS))
`endif

/* File: rtl/dpr_collision_top.sv */
// Dual-port memory with output hold, write-through and cross-port collision handling.
// Functional notes
// - Disabled port holds its read bus.
// - Setup window matters only for same-address writes.
// - Write-write violation marks the word invalid.
// - Write-read violation stores data, flags read invalid.
// - Write data appears on writer's bus.
// - Other port's write leaves bus unchanged.
// - Read after settled write returns new value.
`timescale 1ns/1ns
`default_nettype none
`include "dpr_cfg.svh"
module dpr_collision_top
  import dpr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire dpr_req_t firstPortReq,
  input wire dpr_req_t secondPortReq,
  output dpr_data_t firstPortReadBus,
  output dpr_data_t secondPortReadBus,
  output logic firstPortReadValid,
  output logic secondPortReadValid
);
  localparam int SetupCyc = `DPR_SETUP_CYC;
  localparam dpr_age_t SetupAge = dpr_age_t'(`DPR_SETUP_CYC);

  dpr_state_t state_ff;
  dpr_state_t nxt_state;
  dpr_wr_t wrA;
  dpr_wr_t wrB;
  dpr_data_t memA;
  dpr_data_t memB;
  logic memGoodA;
  logic memGoodB;
  logic actA;
  logic actB;
  logic wrNowA;
  logic wrNowB;
  logic hitA;
  logic hitB;

  // A port acts only on its own clock tick while enabled.
  assign actA = firstPortReq.tick && firstPortReq.enable;
  assign actB = secondPortReq.tick && secondPortReq.enable;
  assign wrNowA = actA && firstPortReq.writeEn;
  assign wrNowB = actB && secondPortReq.writeEn;

  // True when an access meets a write of the other port inside the setup window.
  function automatic logic inWindow(input dpr_addr_t addr, input logic otherWr,
                                    input dpr_addr_t otherAddr, input dpr_rec_t rec);
    inWindow = (otherWr && otherAddr == addr) ||
               (rec.seen && rec.addr == addr && rec.age < SetupAge);
  endfunction

  function automatic dpr_rec_t ageRec(input dpr_rec_t rec, input logic wr,
                                      input dpr_addr_t addr);
    ageRec = rec;
    if (wr) begin
      ageRec.seen = 1'b1;
      ageRec.addr = addr;
      ageRec.age = dpr_age_t'(1);
    end else if (rec.age != `DPR_AGE_MAX) begin
      ageRec.age = rec.age + dpr_age_t'(1);
    end
  endfunction

  assign hitA = actA && inWindow(firstPortReq.addr, wrNowB, secondPortReq.addr, state_ff.recB);
  assign hitB = actB && inWindow(secondPortReq.addr, wrNowA, firstPortReq.addr, state_ff.recA);

  always_comb begin
    wrA.en = wrNowA;
    wrA.addr = firstPortReq.addr;
    wrA.data = firstPortReq.wrData;
    wrA.bad = hitA && wrNowB;
    wrB.en = wrNowB;
    wrB.addr = secondPortReq.addr;
    wrB.data = secondPortReq.wrData;
    wrB.bad = hitB && wrNowA;
  end

  dpr_store store (
    .clk(clk),
    .reset(reset),
    .clkEn(clkEn),
    .wrA(wrA),
    .wrB(wrB),
    .rdAddrA(firstPortReq.addr),
    .rdAddrB(secondPortReq.addr),
    .rdDataA(memA),
    .rdDataB(memB),
    .rdGoodA(memGoodA),
    .rdGoodB(memGoodB)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_state.recA = ageRec(state_ff.recA, wrNowA, firstPortReq.addr);
    nxt_state.recB = ageRec(state_ff.recB, wrNowB, secondPortReq.addr);
    // Each bus changes only on its own port's access; otherwise it holds.
    if (actA) begin
      if (firstPortReq.writeEn) begin
        nxt_state.busA = firstPortReq.wrData;
        nxt_state.goodA = !(hitA && wrNowB);
      end else begin
        nxt_state.busA = memA;
        nxt_state.goodA = memGoodA && !hitA;
      end
    end
    if (actB) begin
      if (secondPortReq.writeEn) begin
        nxt_state.busB = secondPortReq.wrData;
        nxt_state.goodB = !(hitB && wrNowA);
      end else begin
        nxt_state.busB = memB;
        nxt_state.goodB = memGoodB && !hitB;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= '{recA: '0, recB: '0, busA: `DPR_BUS_RESET, busB: `DPR_BUS_RESET,
                    goodA: 1'b1, goodB: 1'b1};
    end else if (clkEn) begin
      state_ff <= nxt_state;
    end
  end

  assign firstPortReadBus = state_ff.busA;
  assign secondPortReadBus = state_ff.busB;
  assign firstPortReadValid = state_ff.goodA;
  assign secondPortReadValid = state_ff.goodB;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic accA;
  logic accB;
  logic rdA;
  logic rdB;
  assign accA = clkEn && actA;
  assign accB = clkEn && actB;
  assign rdA = accA && !firstPortReq.writeEn;
  assign rdB = accB && !secondPortReq.writeEn;

  hold_bus_first_a: assert property (!accA |=> $stable(firstPortReadBus))
    else $error("first port bus changed while idle");
  hold_bus_second_a: assert property (!accB |=> $stable(secondPortReadBus))
    else $error("second port bus changed while idle");
  mirror_first_a: assert property (clkEn && wrNowA |=>
      firstPortReadBus == $past(firstPortReq.wrData))
    else $error("first port write not mirrored");
  mirror_second_a: assert property (clkEn && wrNowB |=>
      secondPortReadBus == $past(secondPortReq.wrData))
    else $error("second port write not mirrored");
  cross_hold_a: assert property (clkEn && wrNowA && !accB |=>
      $stable(secondPortReadBus) && $stable(secondPortReadValid))
    else $error("second bus moved on first port write");
  rw_invalid_a: assert property (rdA && clkEn && wrNowB &&
      firstPortReq.addr == secondPortReq.addr |=> !firstPortReadValid)
    else $error("colliding read not flagged");
  rw_stored_a: assert property ((clkEn && wrNowA && rdB &&
      firstPortReq.addr == secondPortReq.addr && !wrNowB) ##1
      (rdB && !(wrNowA && clkEn) && secondPortReq.addr == $past(firstPortReq.addr))
      |=> SetupCyc != 1 || (secondPortReadValid &&
      secondPortReadBus == $past(firstPortReq.wrData, 2)))
    else $error("write lost in write-read collision");
  ww_invalid_a: assert property ((clkEn && wrNowA && wrNowB &&
      firstPortReq.addr == secondPortReq.addr) ##1
      (rdA && !(clkEn && wrNowB) && firstPortReq.addr == $past(firstPortReq.addr))
      |=> !firstPortReadValid)
    else $error("double write not invalidated");
  fresh_read_a: assert property ((clkEn && wrNowB && !accA) ##1
      (rdA && !(clkEn && wrNowB) && firstPortReq.addr == $past(secondPortReq.addr))
      |=> SetupCyc != 1 || (firstPortReadValid &&
      firstPortReadBus == $past(secondPortReq.wrData, 2)))
    else $error("read missed settled write");

  // Companion checks for the mirror-image port, same-address double writes, the no-collision case and the clock-enable freeze.
  cross_hold_b_a: assert property (clkEn && wrNowB && !accA |=>
      $stable(firstPortReadBus) && $stable(firstPortReadValid))
    else $error("first bus moved on second port write");
  rw_invalid_b_a: assert property (rdB && clkEn && wrNowA &&
      firstPortReq.addr == secondPortReq.addr |=> !secondPortReadValid)
    else $error("colliding second read not flagged");
  ww_writers_a: assert property (clkEn && wrNowA && wrNowB &&
      firstPortReq.addr == secondPortReq.addr |=>
      !firstPortReadValid && !secondPortReadValid)
    else $error("double writers not flagged");
  split_writes_a: assert property (clkEn && wrNowA && wrNowB &&
      firstPortReq.addr != secondPortReq.addr |=>
      firstPortReadValid && secondPortReadValid)
    else $error("independent writes flagged");
  clean_write_a: assert property (clkEn && wrNowA &&
      !(wrNowB && firstPortReq.addr == secondPortReq.addr) |=> firstPortReadValid)
    else $error("clean first write flagged");
  freeze_all_a: assert property (!clkEn |=>
      $stable(firstPortReadBus) && $stable(secondPortReadBus) &&
      $stable(firstPortReadValid) && $stable(secondPortReadValid))
    else $error("outputs moved while frozen");

  cover_ww_c: cover property (clkEn && wrNowA && wrNowB && firstPortReq.addr == secondPortReq.addr);
  cover_rw_c: cover property (rdA && clkEn && wrNowB && firstPortReq.addr == secondPortReq.addr);
  cover_fresh_c: cover property ((clkEn && wrNowB) ##1 (rdA && !hitA));
  cover_hold_c: cover property (accA ##1 !accA [*3]);
endmodule
`default_nettype wire

/* File: rtl/dpr_pkg.sv */
// Types shared by the dual-port memory files.
`include "dpr_cfg.svh"
package dpr_pkg;
  typedef logic [`DPR_ADDR_W-1:0] dpr_addr_t;
  typedef logic [`DPR_DATA_W-1:0] dpr_data_t;
  typedef logic [`DPR_AGE_W-1:0] dpr_age_t;
  typedef struct packed {
    logic tick;
    logic enable;
    logic writeEn;
    dpr_addr_t addr;
    dpr_data_t wrData;
  } dpr_req_t;
  typedef struct packed {
    logic en;
    logic bad;
    dpr_addr_t addr;
    dpr_data_t data;
  } dpr_wr_t;
  typedef struct packed {
    logic seen;
    dpr_addr_t addr;
    dpr_age_t age;
  } dpr_rec_t;
  typedef struct packed {
    dpr_rec_t recA;
    dpr_rec_t recB;
    dpr_data_t busA;
    dpr_data_t busB;
    logic goodA;
    logic goodB;
  } dpr_state_t;
endpackage

/* File: rtl/dpr_store.sv */
// Storage array with a validity flag per word and two write and two read ports.
`timescale 1ns/1ns
`default_nettype none
`include "dpr_cfg.svh"
module dpr_store
  import dpr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire dpr_wr_t wrA,
  input wire dpr_wr_t wrB,
  input wire dpr_addr_t rdAddrA,
  input wire dpr_addr_t rdAddrB,
  output dpr_data_t rdDataA,
  output dpr_data_t rdDataB,
  output logic rdGoodA,
  output logic rdGoodB
);
  dpr_data_t mem [`DPR_DEPTH];
  logic [`DPR_DEPTH-1:0] badWord_ff;
  logic [`DPR_DEPTH-1:0] nxt_badWord;

  // Port A is applied last, so a same-word double write keeps A's value but is flagged bad.
  always_ff @(posedge clk) begin
    if (clkEn && wrB.en) begin
      mem[wrB.addr] <= wrB.data;
    end
    if (clkEn && wrA.en) begin
      mem[wrA.addr] <= wrA.data;
    end
  end

  always_comb begin
    nxt_badWord = badWord_ff;
    if (wrB.en) begin
      nxt_badWord[wrB.addr] = wrB.bad;
    end
    if (wrA.en) begin
      nxt_badWord[wrA.addr] = wrA.bad | (wrB.en && wrB.addr == wrA.addr && wrB.bad);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      badWord_ff <= '0;
    end else if (clkEn) begin
      badWord_ff <= nxt_badWord;
    end
  end

  assign rdDataA = mem[rdAddrA];
  assign rdDataB = mem[rdAddrB];
  assign rdGoodA = !badWord_ff[rdAddrA];
  assign rdGoodB = !badWord_ff[rdAddrB];
endmodule
`default_nettype wire

/* File: sim/dpr_user_port.sv */
// User logic model that drives one port of the dual-port memory.
`timescale 1ns/1ns
`default_nettype none
module dpr_user_port
  import dpr_pkg::*;
(
  output var dpr_req_t req
);
  initial req = '0;
  // Presents one access; the caller keeps it for exactly one clock.
  task automatic put(input logic en, input logic we, input dpr_addr_t a, input dpr_data_t d);
    req = {1'b1, en, we, a, d};
  endtask
  // Idle lines carry inverted junk so a stale value is never taken for data.
  task automatic rest();
    req = {1'b0, 1'b0, 1'b0, ~req.addr, ~req.wrData};
  endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the dual-port memory collision block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import dpr_pkg::*;
  logic clk, reset, clkEn, valA, valB, expValA, expValB;
  dpr_req_t reqA, reqB;
  dpr_data_t busA, busB, expBusA, expBusB;
  int failures = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h542d_b2aa;
  dpr_data_t mem [256];
  bit bad [256];
  dpr_user_port portA (.req(reqA));
  dpr_user_port portB (.req(reqB));
  dpr_collision_top DUT (.clk(clk), .reset(reset), .clkEn(clkEn), .firstPortReq(reqA),
    .secondPortReq(reqB), .firstPortReadBus(busA), .secondPortReadBus(busB),
    .firstPortReadValid(valA), .secondPortReadValid(valB));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Bus and valid a port should show after one access, given what the other port does.
  function automatic logic [16:0] expect_port(input logic en, we, input dpr_addr_t a,
      input dpr_data_t d, input logic oEn, oWe, input dpr_addr_t oa, input logic [16:0] held);
    if (!en) return held;
    if (we) return {d, !(oEn && oWe && oa == a)};
    return {mem[a], !bad[a] && !(oEn && oWe && oa == a)};
  endfunction
  task automatic chk_data(input string what, input dpr_data_t exp, input dpr_data_t got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_flag(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic step(input logic enA, wA, input dpr_addr_t aA, input dpr_data_t dA,
      input logic enB, wB, input dpr_addr_t aB, input dpr_data_t dB);
    logic [16:0] nA, nB;
    portA.put(enA, wA, aA, dA);
    portB.put(enB, wB, aB, dB);
    if (clkEn) begin
      nA = expect_port(enA, wA, aA, dA, enB, wB, aB, {expBusA, expValA});
      nB = expect_port(enB, wB, aB, dB, enA, wA, aA, {expBusB, expValB});
      {expBusA, expValA} = nA;
      {expBusB, expValB} = nB;
      if (enB && wB) begin
        mem[aB] = dB;
        bad[aB] = 1'b0;
      end
      if (enA && wA) begin
        mem[aA] = dA;
        bad[aA] = enB && wB && aB == aA;
      end
    end
    @(negedge clk);
    chk_data("busA", expBusA, busA);
    chk_data("busB", expBusB, busB);
    chk_flag("validA", expValA, valA);
    chk_flag("validB", expValB, valB);
  endtask
  // Reset clears buses and invalid marks but leaves the stored words alone.
  task automatic do_reset();
    reset = 1'b1;
    repeat (3) @(negedge clk);
    expBusA = '0;
    expBusB = '0;
    expValA = 1'b1;
    expValB = 1'b1;
    foreach (bad[i]) bad[i] = 1'b0;
    chk_data("busA", expBusA, busA);
    chk_data("busB", expBusB, busB);
    reset = 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    close_out();
  end
  initial begin
    logic [31:0] r;
    reset = 1'b1;
    clkEn = 1'b1;
    do_reset();
    for (int i = 0; i < 128; i++)
      step(1'b1, 1'b1, i[7:0], dpr_data_t'(rnd()), 1'b1, 1'b1, 8'(i + 128), dpr_data_t'(rnd()));
    step(1'b1, 1'b1, 8'h00, 16'hAAAA, 1'b1, 1'b0, 8'h00, '0);
    step(1'b0, 1'b0, '0, '0, 1'b1, 1'b0, 8'h00, '0);
    step(1'b1, 1'b1, 8'h7E, 16'h9999, 1'b0, 1'b0, '0, '0);
    step(1'b0, 1'b0, '0, '0, 1'b1, 1'b0, 8'h7E, '0);
    step(1'b1, 1'b1, 8'h10, 16'h1234, 1'b1, 1'b1, 8'h10, 16'h5678);
    step(1'b1, 1'b0, 8'h10, '0, 1'b1, 1'b1, 8'h11, 16'h0F0F);
    step(1'b0, 1'b0, '0, '0, 1'b1, 1'b1, 8'h10, 16'h4321);
    step(1'b1, 1'b0, 8'h10, '0, 1'b0, 1'b0, '0, '0);
    clkEn = 1'b0;
    step(1'b1, 1'b1, 8'h20, 16'hDEAD, 1'b1, 1'b1, 8'h21, 16'hBEEF);
    clkEn = 1'b1;
    step(1'b1, 1'b0, 8'h20, '0, 1'b1, 1'b0, 8'h21, '0);
    for (int i = 0; i < 400; i++) begin
      r = rnd();
      clkEn = r[31:29] != 3'h0;
      step(r[0], r[1], {5'h00, r[4:2]}, dpr_data_t'(rnd()), r[8], r[9], {5'h00, r[12:10]},
        r[31:16]);
    end
    clkEn = 1'b1;
    do_reset();
    step(1'b1, 1'b0, 8'h7E, '0, 1'b1, 1'b0, 8'h00, '0);
    portA.rest();
    portB.rest();
    close_out();
  end
endmodule
`default_nettype wire
